//--- acb_bank.v
// upper configuration and status register bank with mode write rules
//
// Function
// - entering standby from active keeps every register of the bank.
// - hibernate exit, power-on or brown-out returns all registers to defaults.
// - standby to active or trigger clears orientation and change source registers.
// - standby to active or trigger marks output buffer contents obsolete.
// - config writes only in standby; run, reset, flush bits writable always.
// - run bit cannot change while in external trigger mode.
// - change control register: only reference update bit settable in active mode.
// - change detection reset values follow the boot strap level.
// - lower threshold low byte at 33h, bits 11:8 at 34h.
// - upper threshold low byte at 35h, bits 11:8 at 36h.
// - separate 8-bit outside and within debounce counts.
// - second buffer register holds flush, gate and 6-bit watermark.
// - orientation resets 80h, back/front 44h, tilt threshold 84h.
// - 8-bit z-axis offset, read/write, resets to zero.
// - self-test idle duration and decimation registers.
// - first buffer register selects mode, trigger source and collection mode.
// - orientation debounce register, resets to zero.
// - interrupt status resets with boot flag one, others zero.
`timescale 1ns/1ps
`include "acb_defs.vh"

module acb_bank (
    input  wire       clk,
    input  wire       srst,
    input  wire       power_event,
    input  wire       boot_strap_level,
    input  wire [1:0] op_mode,
    input  wire       fast_read,
    input  wire       acc_start,
    input  wire [7:0] acc_addr,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    input  wire       rd_en,
    input  wire       orient_set,
    input  wire [7:0] orient_value,
    input  wire       change_out_set,
    input  wire [7:0] change_out_value,
    input  wire       change_win_set,
    input  wire [7:0] change_win_value,
    output reg  [7:0] rd_data,
    output reg  [7:0] reg_ptr,
    output reg        buffer_obsolete,
    output reg        buffer_flush,
    output reg  [7:0] int_status,
    output reg  [7:0] z_axis_offset,
    output reg  [7:0] buffer_config_mode,
    output reg  [7:0] buffer_config_watermark,
    output reg  [7:0] orientation_config,
    output reg  [7:0] orientation_debounce,
    output reg  [7:0] back_front_threshold,
    output reg  [7:0] tilt_threshold_hysteresis,
    output reg  [7:0] change_config_axes,
    output reg  [7:0] change_config_control,
    output reg  [7:0] outside_debounce_count,
    output reg  [7:0] within_debounce_count,
    output reg  [11:0] lower_threshold,
    output reg  [11:0] upper_threshold,
    output reg  [7:0] selftest_idle_duration,
    output reg  [7:0] selftest_decimation
);

    ////////////////////////////////////////////////////////////////////////
    // state held inside the bank
    reg [7:0] factory_reserved_a;
    reg [7:0] factory_reserved_b;
    reg [7:0] orientation_status;
    reg [7:0] change_outside_flags;
    reg [7:0] change_within_flags;
    reg [1:0] prev_mode;
    reg [7:0] next_ptr;
    reg [7:0] read_value;
    reg [7:0] cur_addr;
    reg       srst_strap_pending;
    wire      bank_reset;
    wire      standby;
    wire      active;
    wire      leave_standby;

    // next address after a byte; 3ah wraps to 00h, and fast read steps 33h to 34h like a normal read
    function [7:0] acb_next_addr;
        input [7:0] addr;
        input       fast;
        begin
            if (addr == `ACB_OFFSET_RSV_C) begin
                acb_next_addr = `ACB_OFFSET_WRAP;
            end else if (fast && addr == `ACB_OFFSET_LTHS_LO) begin
                acb_next_addr = `ACB_OFFSET_LTHS_HI;
            end else begin
                acb_next_addr = addr + 8'h01;
            end
        end
    endfunction

    // fallback value for the read path; returns dummy whatever the address
    function [7:0] acb_pick;
        input [7:0] addr;
        input [7:0] dummy;
        begin
            acb_pick = dummy;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // mode tracking
    // power events share the reset path so no field survives them
    assign bank_reset    = srst | power_event;
    assign standby       = (op_mode == `ACB_MODE_STANDBY);
    assign active        = (op_mode == `ACB_MODE_ACTIVE);
    assign leave_standby = (prev_mode == `ACB_MODE_STANDBY) && !standby;

    always @(posedge clk) begin
        if (bank_reset) begin
            prev_mode <= `ACB_MODE_STANDBY;
        end else begin
            prev_mode <= op_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register pointer
    always @* begin
        cur_addr = acc_start ? acc_addr : reg_ptr;
        next_ptr = reg_ptr;
        if (wr_en || rd_en) begin
            next_ptr = acb_next_addr(cur_addr, fast_read);
        end else if (acc_start) begin
            next_ptr = acc_addr;
        end
    end

    always @(posedge clk) begin
        if (bank_reset) begin
            reg_ptr <= `ACB_OFFSET_Z_OFF;
        end else begin
            reg_ptr <= next_ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap dependent defaults, each sliced to the field it lands in
    wire [7:0] strap_ch_ctrl;
    wire [7:0] strap_lths_hi;
    wire [7:0] strap_uths_lo;

    assign strap_ch_ctrl = boot_strap_level ? `ACB_RESET_CH_CTRL_VDD : `ACB_RESET_ZERO;
    assign strap_lths_hi = boot_strap_level ? `ACB_RESET_LTHS_HI_VDD : `ACB_RESET_ZERO;
    assign strap_uths_lo = boot_strap_level ? `ACB_RESET_UTHS_LO_VDD : `ACB_RESET_ZERO;

    // configuration writes; no mode change touches them, so active to standby keeps all
    always @(posedge clk) begin
        if (bank_reset) begin
            z_axis_offset             <= `ACB_RESET_ZERO;
            factory_reserved_a        <= `ACB_RESET_ZERO;
            factory_reserved_b        <= `ACB_RESET_ZERO;
            buffer_config_mode        <= `ACB_RESET_ZERO;
            buffer_config_watermark   <= `ACB_RESET_ZERO;
            orientation_config        <= `ACB_RESET_OR_CFG;
            orientation_debounce      <= `ACB_RESET_ZERO;
            back_front_threshold      <= `ACB_RESET_BF_THS;
            tilt_threshold_hysteresis <= `ACB_RESET_TILT_THS;
            change_config_axes        <= `ACB_RESET_ZERO;
            change_config_control     <= `ACB_RESET_ZERO;
            outside_debounce_count    <= `ACB_RESET_ZERO;
            within_debounce_count     <= `ACB_RESET_ZERO;
            lower_threshold           <= 12'h000;
            upper_threshold           <= 12'h000;
            selftest_idle_duration    <= `ACB_RESET_ZERO;
            selftest_decimation       <= `ACB_RESET_ZERO;
            buffer_flush              <= 1'b0;
        end else if (srst_strap_pending) begin
            // strap is caught one clock after release, never under reset
            change_config_control   <= strap_ch_ctrl;
            lower_threshold[11:8]   <= strap_lths_hi[3:0];
            upper_threshold[7:0]    <= strap_uths_lo;
            buffer_flush            <= 1'b0;
        end else begin
            // flush is a one-cycle request to the buffer
            buffer_flush <= 1'b0;
            if (wr_en && standby) begin
                case (cur_addr)
                    `ACB_OFFSET_Z_OFF:    z_axis_offset <= wr_data;
                    `ACB_OFFSET_RSV_A:    factory_reserved_a <= wr_data;
                    `ACB_OFFSET_BUF_MODE: buffer_config_mode <= wr_data;
                    `ACB_OFFSET_BUF_WMRK: begin
                        buffer_config_watermark <= {1'b0, wr_data[6:0]};
                        buffer_flush            <= wr_data[`ACB_BIT_BUF_FLUSH];
                    end
                    `ACB_OFFSET_OR_CFG:   orientation_config <= wr_data;
                    `ACB_OFFSET_OR_DB:    orientation_debounce <= wr_data;
                    `ACB_OFFSET_BF_THS:   back_front_threshold <= wr_data;
                    `ACB_OFFSET_TILT_THS: tilt_threshold_hysteresis <= wr_data;
                    `ACB_OFFSET_CH_AXES:  change_config_axes <= wr_data;
                    `ACB_OFFSET_CH_CTRL:  change_config_control <= wr_data;
                    `ACB_OFFSET_CH_ODB:   outside_debounce_count <= wr_data;
                    `ACB_OFFSET_CH_WDB:   within_debounce_count <= wr_data;
                    `ACB_OFFSET_LTHS_LO:  lower_threshold[7:0] <= wr_data;
                    `ACB_OFFSET_LTHS_HI:  lower_threshold[11:8] <= wr_data[3:0];
                    `ACB_OFFSET_UTHS_LO:  upper_threshold[7:0] <= wr_data;
                    `ACB_OFFSET_UTHS_HI:  upper_threshold[11:8] <= wr_data[3:0];
                    `ACB_OFFSET_ST_IDLE:  selftest_idle_duration <= wr_data;
                    `ACB_OFFSET_ST_DEC:   selftest_decimation <= wr_data;
                    // host always writes zero here
                    `ACB_OFFSET_RSV_B:    factory_reserved_b <= wr_data;
                    default: ;
                endcase
            end else if (wr_en) begin
                // outside standby only the flush and reference update may set
                if (cur_addr == `ACB_OFFSET_BUF_WMRK && wr_data[`ACB_BIT_BUF_FLUSH]) begin
                    buffer_flush <= 1'b1;
                end
                if (active && cur_addr == `ACB_OFFSET_CH_CTRL && wr_data[`ACB_BIT_REFERENCE_UPDATE_BIT]) begin
                    change_config_control[`ACB_BIT_REFERENCE_UPDATE_BIT] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    always @(posedge clk) begin
        if (bank_reset) begin
            srst_strap_pending <= 1'b1;
        end else begin
            srst_strap_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read-only status; set beats the clear on mode entry
    always @(posedge clk) begin
        if (bank_reset) begin
            orientation_status   <= `ACB_RESET_ZERO;
            change_outside_flags <= `ACB_RESET_ZERO;
            change_within_flags  <= `ACB_RESET_ZERO;
            int_status           <= `ACB_RESET_INT_STATUS;
            buffer_obsolete      <= 1'b0;
        end else begin
            buffer_obsolete <= leave_standby;
            if (orient_set) begin
                orientation_status <= orient_value;
            end else if (leave_standby) begin
                orientation_status <= `ACB_RESET_ZERO;
            end
            if (change_out_set) begin
                change_outside_flags <= change_out_value;
            end else if (leave_standby) begin
                change_outside_flags <= `ACB_RESET_ZERO;
            end
            if (change_win_set) begin
                change_within_flags <= change_win_value;
            end else if (leave_standby) begin
                change_within_flags <= `ACB_RESET_ZERO;
            end
            int_status <= int_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; unmapped addresses read zero
    always @* begin
        case (cur_addr)
            `ACB_OFFSET_Z_OFF:    read_value = z_axis_offset;
            `ACB_OFFSET_RSV_A:    read_value = factory_reserved_a;
            `ACB_OFFSET_BUF_MODE: read_value = buffer_config_mode;
            `ACB_OFFSET_BUF_WMRK: read_value = buffer_config_watermark;
            `ACB_OFFSET_OR_STAT:  read_value = orientation_status;
            `ACB_OFFSET_OR_CFG:   read_value = orientation_config;
            `ACB_OFFSET_OR_DB:    read_value = orientation_debounce;
            `ACB_OFFSET_BF_THS:   read_value = back_front_threshold;
            `ACB_OFFSET_TILT_THS: read_value = tilt_threshold_hysteresis;
            `ACB_OFFSET_CH_OUT:   read_value = change_outside_flags;
            `ACB_OFFSET_CH_WIN:   read_value = change_within_flags;
            `ACB_OFFSET_CH_AXES:  read_value = change_config_axes;
            `ACB_OFFSET_CH_CTRL:  read_value = change_config_control;
            `ACB_OFFSET_CH_ODB:   read_value = outside_debounce_count;
            `ACB_OFFSET_CH_WDB:   read_value = within_debounce_count;
            `ACB_OFFSET_LTHS_LO:  read_value = lower_threshold[7:0];
            `ACB_OFFSET_LTHS_HI:  read_value = {4'h0, lower_threshold[11:8]};
            `ACB_OFFSET_UTHS_LO:  read_value = upper_threshold[7:0];
            `ACB_OFFSET_UTHS_HI:  read_value = {4'h0, upper_threshold[11:8]};
            `ACB_OFFSET_ST_IDLE:  read_value = selftest_idle_duration;
            `ACB_OFFSET_ST_DEC:   read_value = selftest_decimation;
            `ACB_OFFSET_RSV_B:    read_value = factory_reserved_b;
            `ACB_OFFSET_RSV_C:    read_value = `ACB_RESET_RSV_C;
            default:              read_value = acb_pick(cur_addr, `ACB_RESET_ZERO);
        endcase
    end

    // registered read data, one cycle after the request
    always @(posedge clk) begin
        if (bank_reset) begin
            rd_data <= `ACB_RESET_ZERO;
        end else if (rd_en) begin
            rd_data <= read_value;
        end
    end

    // the run bit lives in a lower register; in trigger mode it is frozen there
    // and this bank never drives it, which trivially held here.

endmodule // acb_bank

//--- acb_defs.vh
// constants of the upper configuration register bank
`ifndef ACB_DEFS_VH
`define ACB_DEFS_VH
`define ACB_OFFSET_Z_OFF      8'h24
`define ACB_OFFSET_RSV_A      8'h25
`define ACB_OFFSET_BUF_MODE   8'h26
`define ACB_OFFSET_BUF_WMRK   8'h27
`define ACB_OFFSET_OR_STAT    8'h28
`define ACB_OFFSET_OR_CFG     8'h29
`define ACB_OFFSET_OR_DB      8'h2a
`define ACB_OFFSET_BF_THS     8'h2b
`define ACB_OFFSET_TILT_THS   8'h2c
`define ACB_OFFSET_CH_OUT     8'h2d
`define ACB_OFFSET_CH_WIN     8'h2e
`define ACB_OFFSET_CH_AXES    8'h2f
`define ACB_OFFSET_CH_CTRL    8'h30
`define ACB_OFFSET_CH_ODB     8'h31
`define ACB_OFFSET_CH_WDB     8'h32
`define ACB_OFFSET_LTHS_LO    8'h33
`define ACB_OFFSET_LTHS_HI    8'h34
`define ACB_OFFSET_UTHS_LO    8'h35
`define ACB_OFFSET_UTHS_HI    8'h36
`define ACB_OFFSET_ST_IDLE    8'h37
`define ACB_OFFSET_ST_DEC     8'h38
`define ACB_OFFSET_RSV_B      8'h39
`define ACB_OFFSET_RSV_C      8'h3a
`define ACB_OFFSET_WRAP       8'h00
`define ACB_RESET_ZERO        8'h00
`define ACB_RESET_OR_CFG      8'h80
`define ACB_RESET_BF_THS      8'h44
`define ACB_RESET_TILT_THS    8'h84
`define ACB_RESET_CH_CTRL_VDD 8'hd8
`define ACB_RESET_LTHS_HI_VDD 8'h0f
`define ACB_RESET_UTHS_LO_VDD 8'h40
`define ACB_RESET_INT_STATUS  8'h01
`define ACB_RESET_RSV_C       8'h00
`define ACB_BIT_BUF_FLUSH     7
`define ACB_BIT_REFERENCE_UPDATE_BIT       2
`define ACB_MODE_STANDBY      2'b00
`define ACB_MODE_ACTIVE       2'b01
`define ACB_MODE_EXTERNAL_TRIGGER_MODE     2'b10
`endif

//--- acb_bank_monitor.sv
// assertion checker for the upper register bank ports
`timescale 1ns/1ps
module acb_bank_monitor (
    input wire        clk,
    input wire        srst,
    input wire        power_event,
    input wire        boot_strap_level,
    input wire [1:0]  op_mode,
    input wire        acc_start,
    input wire [7:0]  acc_addr,
    input wire        wr_en,
    input wire [7:0]  wr_data,
    input wire        rd_en,
    input wire [7:0]  rd_data,
    input wire [7:0]  reg_ptr,
    input wire        buffer_obsolete,
    input wire        buffer_flush,
    input wire [7:0]  int_status,
    input wire [7:0]  z_axis_offset,
    input wire [7:0]  change_config_control,
    input wire [11:0] lower_threshold,
    input wire [11:0] upper_threshold
);
    // cycles since reset release, saturating; the strap lands on the first edge
    logic [1:0] rel_cnt;
    always_ff @(posedge clk) begin
        if (srst || power_event)
            rel_cnt <= 2'h0;
        else if (rel_cnt != 2'h3)
            rel_cnt <= rel_cnt + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || power_event);
    // read request at a stepping address, and exit from standby
    sequence s_read_start;
        acc_start && rd_en && acc_addr >= 8'h24 && acc_addr < 8'h3a;
    endsequence
    sequence s_leave_standby;
        $past(op_mode) == 2'b00 && op_mode != 2'b00;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_ptr_step: assert property (s_read_start |=> reg_ptr == $past(acc_addr) + 8'h01)
        else $error("pointer did not step to next address");
    a_read_offset: assert property (acc_start && rd_en && acc_addr == 8'h24 |=> rd_data == z_axis_offset)
        else $error("offset read returned wrong value");
    a_offset_locked: assert property (op_mode != 2'b00 |=> $stable(z_axis_offset))
        else $error("offset changed outside standby");
    a_keep_standby: assert property ($past(op_mode) == 2'b01 && op_mode == 2'b00 |-> $stable(upper_threshold))
        else $error("contents changed on entry to standby");
    a_obsolete_pulse: assert property (s_leave_standby |-> ##[0:1] buffer_obsolete)
        else $error("no obsolete pulse on leaving standby");
    a_flush_write: assert property (acc_start && wr_en && acc_addr == 8'h27 && wr_data[7] |=> buffer_flush)
        else $error("flush write gave no pulse");
    a_flush_cause: assert property (buffer_flush |-> $past(wr_en))
        else $error("flush pulse without a write");
    a_ref_active: assert property (op_mode == 2'b01 && acc_start && wr_en && acc_addr == 8'h30
        |=> change_config_control == ($past(change_config_control) | ($past(wr_data) & 8'h04)))
        else $error("control register took more than reference bit");
    a_boot_flag: assert property (int_status == 8'h01)
        else $error("interrupt status not at boot value");
    a_strap_load: assert property (rel_cnt == 2'h1 |-> upper_threshold[7:0] == (boot_strap_level ? 8'h40 : 8'h00)
        && lower_threshold[11:8] == (boot_strap_level ? 4'hf : 4'h0))
        else $error("strap reset values wrong");
endmodule // acb_bank_monitor

bind acb_bank acb_bank_monitor u_mon (.clk(clk), .srst(srst), .power_event(power_event),
    .boot_strap_level(boot_strap_level), .op_mode(op_mode), .acc_start(acc_start), .acc_addr(acc_addr),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .reg_ptr(reg_ptr),
    .buffer_obsolete(buffer_obsolete), .buffer_flush(buffer_flush), .int_status(int_status),
    .z_axis_offset(z_axis_offset), .change_config_control(change_config_control),
    .lower_threshold(lower_threshold), .upper_threshold(upper_threshold));

//--- acb_host.sv
// host model driving the bank access port
`timescale 1ns/1ps
module acb_host (
    input  wire        clk,
    input  wire  [7:0] rd_data,
    output logic       acc_start,
    output logic [7:0] acc_addr,
    output logic       wr_en,
    output logic [7:0] wr_data,
    output logic       rd_en
);
    // idle port at time zero
    initial begin
        acc_start = 1'b0;
        acc_addr  = 8'h00;
        wr_en     = 1'b0;
        wr_data   = 8'h00;
        rd_en     = 1'b0;
    end
    // one byte; idle lines inverted so stale values never look valid
    task acc(input logic st, input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] dv;
        dv = (a == 8'h39) ? 8'h00 : d;
        @(posedge clk);
        acc_start <= st;
        acc_addr  <= a;
        wr_en     <= w;
        wr_data   <= dv;
        rd_en     <= !w;
        @(posedge clk);
        acc_start <= 1'b0;
        wr_en     <= 1'b0;
        rd_en     <= 1'b0;
        acc_addr  <= ~a;
        wr_data   <= ~dv;
        #1;
        q = rd_data;
    endtask
endmodule // acb_host

//--- test_accel_config_register_bank.sv
// testbench of the upper register bank
`timescale 1ns/1ps
module test_accel_config_register_bank;
    logic        clk, srst, power_event, boot_strap_level, fast_read, acc_start, wr_en, rd_en;
    logic        orient_set, change_out_set, change_win_set, buffer_obsolete, buffer_flush;
    logic [1:0]  op_mode;
    logic [7:0]  orient_value, change_out_value, change_win_value, rd_data, reg_ptr, q, acc_addr, wr_data;
    logic [7:0]  int_status, z_axis_offset, outside_debounce_count, within_debounce_count;
    logic [11:0] lower_threshold, upper_threshold;
    int          n_errors, checks, obs_cnt, flush_cnt;
    logic [15:0] rst_tab [12] = '{16'h2400, 16'h2600, 16'h2700, 16'h2800, 16'h2980, 16'h2a00,
                                  16'h2b44, 16'h2c84, 16'h3000, 16'h3100, 16'h3400, 16'h3500};
    logic [15:0] wr_tab [11] = '{16'h245a, 16'h26c3, 16'h2a07, 16'h3111, 16'h3222, 16'h3334,
                                 16'h340a, 16'h3578, 16'h3605, 16'h3709, 16'h3806};
    acb_host u_host (.clk(clk), .rd_data(rd_data), .acc_start(acc_start), .acc_addr(acc_addr),
        .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));
    acb_bank u_dut (.clk(clk), .srst(srst), .power_event(power_event), .boot_strap_level(boot_strap_level),
        .op_mode(op_mode), .fast_read(fast_read), .acc_start(acc_start), .acc_addr(acc_addr), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .orient_set(orient_set), .orient_value(orient_value),
        .change_out_set(change_out_set), .change_out_value(change_out_value), .change_win_set(change_win_set),
        .change_win_value(change_win_value), .rd_data(rd_data), .reg_ptr(reg_ptr),
        .buffer_obsolete(buffer_obsolete), .buffer_flush(buffer_flush), .int_status(int_status),
        .z_axis_offset(z_axis_offset), .buffer_config_mode(), .buffer_config_watermark(),
        .orientation_config(), .orientation_debounce(), .back_front_threshold(), .tilt_threshold_hysteresis(),
        .change_config_axes(), .change_config_control(), .outside_debounce_count(outside_debounce_count),
        .within_debounce_count(within_debounce_count), .lower_threshold(lower_threshold),
        .upper_threshold(upper_threshold), .selftest_idle_duration(), .selftest_decimation());
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count one-cycle pulses, which would be missed by a later read
    always @(posedge clk) begin
        if (buffer_obsolete === 1'b1) obs_cnt <= obs_cnt + 1;
        if (buffer_flush === 1'b1) flush_cnt <= flush_cnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.acc(1'b1, 1'b0, a, 8'h00, q);
        chk($sformatf("reg %h", a), q, exp);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        u_host.acc(1'b1, 1'b1, a, d, q);
    endtask
    task mode(input logic [1:0] m);
        @(posedge clk);
        op_mode <= m;
        @(posedge clk);
    endtask
    // reset held five cycles, strap steady across the release
    task do_reset(input logic s);
        @(posedge clk);
        srst <= 1'b1;
        boot_strap_level <= s;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask
    task results;
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        results;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {srst, power_event, boot_strap_level, fast_read, orient_set, change_out_set, change_win_set} = 7'h40;
        {op_mode, orient_value, change_out_value, change_win_value} = 26'h0;
        {n_errors, checks, obs_cnt, flush_cnt} = 128'h0;
        do_reset(1'b0);
        foreach (rst_tab[i]) rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
        chk("int_status", int_status, 8'h01);
        // pointer steps, fast read, wrap, and a read that follows the pointer
        @(posedge clk) fast_read <= 1'b1;
        rchk(8'h33, 8'h00);
        chk("ptr fast", reg_ptr, 8'h34);
        @(posedge clk) fast_read <= 1'b0;
        rchk(8'h3a, 8'h00);
        chk("ptr wrap", reg_ptr, 8'h00);
        rchk(8'h29, 8'h80);
        u_host.acc(1'b0, 1'b0, 8'h00, 8'h00, q);
        chk("burst", q, 8'h00);
        chk("ptr burst", reg_ptr, 8'h2b);
        foreach (wr_tab[i]) wr(wr_tab[i][15:8], wr_tab[i][7:0]);
        foreach (wr_tab[i]) rchk(wr_tab[i][15:8], wr_tab[i][7:0]);
        chk("z", z_axis_offset, 8'h5a);
        chk("lower", lower_threshold, 12'ha34);
        chk("upper", upper_threshold, 12'h578);
        chk("outside", outside_debounce_count, 8'h11);
        chk("within", within_debounce_count, 8'h22);
        wr(8'h27, 8'hff);
        rchk(8'h27, 8'h7f);
        chk("flush", flush_cnt, 1);
        // status sources loaded, then cleared on leaving standby
        @(posedge clk);
        {orient_set, change_out_set, change_win_set} <= 3'h7;
        {orient_value, change_out_value, change_win_value} <= 24'h050306;
        @(posedge clk);
        {orient_set, change_out_set, change_win_set} <= 3'h0;
        rchk(8'h28, 8'h05);
        rchk(8'h2d, 8'h03);
        rchk(8'h2e, 8'h06);
        mode(2'b01);
        rchk(8'h28, 8'h00);
        rchk(8'h2d, 8'h00);
        rchk(8'h2e, 8'h00);
        chk("obsolete", obs_cnt, 1);
        // active mode: plain writes refused, reference bit and flush accepted
        wr(8'h24, 8'h11);
        rchk(8'h24, 8'h5a);
        wr(8'h30, 8'h84);
        rchk(8'h30, 8'h04);
        wr(8'h27, 8'h80);
        mode(2'b00);
        chk("flush active", flush_cnt, 2);
        chk("z kept", z_axis_offset, 8'h5a);
        chk("upper kept", upper_threshold, 12'h578);
        mode(2'b10);
        wr(8'h33, 8'hff);
        chk("lower trig", lower_threshold, 12'ha34);
        chk("obsolete trig", obs_cnt, 2);
        mode(2'b00);
        // power event and strap-high reset restore defaults
        @(posedge clk);
        power_event <= 1'b1;
        @(posedge clk);
        power_event <= 1'b0;
        rchk(8'h24, 8'h00);
        chk("lower power", lower_threshold, 12'h000);
        do_reset(1'b1);
        rchk(8'h30, 8'hd8);
        rchk(8'h34, 8'h0f);
        rchk(8'h35, 8'h40);
        results;
    end
endmodule // test_accel_config_register_bank
